// *** rtl/ccr_pkg.sv ***
package ccr_pkg;

  // Serial slave address, upper seven bits of the first byte
  localparam logic [6:0] CCR_SLAVE_ADDR = 7'h69;

  // Register indexes
  localparam logic [2:0] CCR_IDX_FREQ_SEL = 3'h0;
  localparam logic [2:0] CCR_IDX_CPU      = 3'h1;
  localparam logic [2:0] CCR_IDX_PCI      = 3'h2;
  localparam logic [2:0] CCR_IDX_FIXED    = 3'h3;
  localparam logic [2:0] CCR_IDX_MEM_HIGH = 3'h4;
  localparam logic [2:0] CCR_IDX_MEM_LOW  = 3'h5;
  localparam logic [2:0] CCR_IDX_CHIP_ID  = 3'h6;
  localparam logic [2:0] CCR_IDX_LAST     = 3'h7;
  localparam int         CCR_NUM_STORED   = 6;

  // Power-up values of the stored bytes
  localparam logic [7:0] CCR_RST_FREQ_SEL = 8'h00;
  localparam logic [7:0] CCR_RST_ENABLES  = 8'hFF;

  // Bits that a write may change, per index 5 down to 0
  localparam logic [5:0][7:0] CCR_WMASK = {8'hFF, 8'hF5, 8'hB3, 8'h7F, 8'h2E, 8'hFF};

  // Strap read-back positions
  localparam int CCR_BIT_STRAP2 = 7;
  localparam int CCR_BIT_STRAP0 = 6;
  localparam int CCR_BIT_STRAP1 = 3;
  localparam int CCR_BIT_STRAP3 = 1;

  // Field positions
  localparam int CCR_BIT_SPREAD_TYPE   = 5;
  localparam int CCR_BIT_SPREAD_AMT    = 7;
  localparam int CCR_BIT_DUAL_SEL      = 7;
  localparam int CCR_BIT_FIXED48_EN    = 5;
  localparam int CCR_BIT_DUAL_EN       = 4;
  localparam int CCR_BIT_REF_SECOND_EN = 1;
  localparam int CCR_BIT_REF_FIRST_EN  = 0;

  // Value returned past the last register
  localparam logic [7:0] CCR_READ_PAST_END = 8'hFF;
  // Arbitrary neutral identification value
  localparam logic [7:0] CCR_CHIP_ID_DEFAULT = 8'hA5;

  // Byte phases of a write transfer
  localparam logic [1:0] CCR_PH_ADDR  = 2'h0;
  localparam logic [1:0] CCR_PH_CMD   = 2'h1;
  localparam logic [1:0] CCR_PH_COUNT = 2'h2;
  localparam logic [1:0] CCR_PH_DATA  = 2'h3;

  localparam logic [2:0] CCR_LAST_BIT = 3'h7;

  typedef enum logic [4:0] {
    CCR_ST_IDLE = 5'h01,
    CCR_ST_RECV = 5'h02,
    CCR_ST_ACK  = 5'h04,
    CCR_ST_SEND = 5'h08,
    CCR_ST_RACK = 5'h10
  } ccr_state_t;

  typedef struct packed {
    logic [2:0]  proc_clk_out;
    logic [6:0]  pci_bus_clk_out;
    logic [13:0] mem_clk_out;
    logic        ref_clk_out_first;
    logic        ref_clk_out_second;
    logic        fixed_48_out;
    logic        dual_rate_fixed_out;
    logic        dual_rate_sel_24;
    logic        spread_down;
    logic        spread_center_wide;
  } ccr_enables_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } ccr_bus_events_t;

endpackage : ccr_pkg

// *** rtl/ccr_bus_events.sv ***
module ccr_bus_events
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic            i_clock,
  input  wire logic            i_resetn,
  // Serial pins, synchronous to the clock
  input  wire logic            i_scl,
  input  wire logic            i_sda,
  // Decoded events
  output ccr_bus_events_t      o_events
);

  logic scl_cur;
  logic scl_prev;
  logic sda_cur;
  logic sda_prev;
  logic next_scl_cur;
  logic next_scl_prev;
  logic next_sda_cur;
  logic next_sda_prev;

  always_comb
  begin
    next_scl_cur  = i_scl;
    next_scl_prev = scl_cur;
    next_sda_cur  = i_sda;
    next_sda_prev = sda_cur;
  end

  // Idle bus level is high on both lines
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      scl_cur  <= 1'b1;
      scl_prev <= 1'b1;
      sda_cur  <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_cur  <= next_scl_cur;
      scl_prev <= next_scl_prev;
      sda_cur  <= next_sda_cur;
      sda_prev <= next_sda_prev;
    end
  end

  always_comb
  begin
    o_events.start    = scl_prev & scl_cur & sda_prev & ~sda_cur;
    o_events.stop     = scl_prev & scl_cur & ~sda_prev & sda_cur;
    o_events.scl_rise = ~scl_prev & scl_cur;
    o_events.scl_fall = scl_prev & ~scl_cur;
    o_events.sda      = sda_cur;
  end

endmodule // ccr_bus_events

// *** rtl/ccr_shift8.sv ***
module ccr_shift8
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  // Control
  input  wire logic       i_load,
  input  wire logic [7:0] i_load_value,
  input  wire logic       i_shift,
  input  wire logic       i_bit,
  // Contents, most significant bit goes out first
  output logic      [7:0] o_data
);

  logic [7:0] data;
  logic [7:0] next_data;

  always_comb
  begin
    next_data = data;
    if (i_load)
    begin
      next_data = i_load_value;
    end
    else if (i_shift)
    begin
      next_data = {data[6:0], i_bit};
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      data <= 8'hFF;
    end
    else
    begin
      data <= next_data;
    end
  end

  assign o_data = data;

endmodule // ccr_shift8

// *** rtl/ccr_clock_regs.sv ***
// How it works
// R1: index 1 bits 3..1 enable processor clocks 2..0
// R2: index 1 bit 5 zero forces half-percent down-spread
// R3: index 2 bits 6..0 enable PCI clocks; bit7 one
// R4: index 3 bit 7 selects 24 or 48 MHz
// R5: index 3 bits 5,4 enable fixed outputs
// R6: index 3 bits 1,0 enable references; 3,2 one
// R7: index 4 bits 7,6,5,4,2,0 enable memory 13..8
// R8: index 5 bit n enables memory clock n
// R9: index 6 is fixed read-only identification byte
// R10: one runs the output; all enables start one
// R11: strap read-back bits latched once, ignore writes
// R12: reserved bits read one and ignore writes
// R13: slave address 1101001, direction bit, byte acknowledged
// R14: master sends dummy command and count first
// R15: defaults load only at power-up reset
// R16: reads stream bytes from index 0 until the master NACKs or sends stop
module ccr_clock_regs
  import ccr_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = CCR_CHIP_ID_DEFAULT
)
(
  // Clock and power-up reset
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  // Frequency-select straps, active low
  input  wire logic [3:0] i_freq_strap_n,
  // Two-wire serial bus
  input  wire logic       i_serial_clock_line,
  input  wire logic       i_serial_data_line,
  output logic            o_serial_data_line,
  output logic            o_serial_data_line_oe,
  // Clock output controls
  output ccr_enables_t    o_enables
);

  ccr_bus_events_t     ev;
  logic [7:0]          shift_data;
  logic                shift_load;
  logic [7:0]          shift_load_value;
  logic                shift_en;
  logic                shift_bit;

  ccr_state_t          state;
  ccr_state_t          next_state;
  logic [2:0]          bit_cnt;
  logic [2:0]          next_bit_cnt;
  logic                byte_done;
  logic                next_byte_done;
  logic [1:0]          phase;
  logic [1:0]          next_phase;
  logic [2:0]          index;
  logic [2:0]          next_index;
  logic                rw_read;
  logic                next_rw_read;
  logic                nack;
  logic                next_nack;
  logic                sda_oe;
  logic                next_sda_oe;

  logic [5:0][7:0]     regs;
  logic [5:0][7:0]     next_regs;
  logic [3:0]          strap_n;
  logic [3:0]          next_strap_n;
  logic                strap_taken;
  logic                next_strap_taken;
  ccr_enables_t        enables;
  ccr_enables_t        next_enables;

  ccr_bus_events u_events (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_scl    (i_serial_clock_line),
    .i_sda    (i_serial_data_line),
    .o_events (ev)
  );

  ccr_shift8 u_shift (
    .i_clock      (i_clock),
    .i_resetn     (i_resetn),
    .i_load       (shift_load),
    .i_load_value (shift_load_value),
    .i_shift      (shift_en),
    .i_bit        (shift_bit),
    .o_data       (shift_data)
  );

  // Byte seen by the master for a given index
  function automatic logic [7:0] read_value(input logic [2:0] idx);
    logic [7:0] v;
    v = CCR_READ_PAST_END;
    if (idx < CCR_IDX_CHIP_ID)
    begin
      v = regs[idx];
    end
    case (idx)
      CCR_IDX_CPU:      v[CCR_BIT_STRAP2] = strap_n[2]; // R11
      CCR_IDX_FIXED:    v[CCR_BIT_STRAP0] = strap_n[0]; // R11
      CCR_IDX_MEM_HIGH:
      begin
        v[CCR_BIT_STRAP1] = strap_n[1]; // R11
        v[CCR_BIT_STRAP3] = strap_n[3]; // R11
      end
      CCR_IDX_CHIP_ID:  v = CHIP_ID; // R9
      default:          v = v;
    endcase
    return v;
  endfunction

  // Straps are caught on the first cycle after power-up reset releases
  always_comb
  begin
    next_strap_n     = strap_n;
    next_strap_taken = 1'b1;
    if (!strap_taken)
    begin
      next_strap_n = i_freq_strap_n; // R11
    end
  end

  // Serial protocol and register writes
  always_comb
  begin
    next_state       = state;
    next_bit_cnt     = bit_cnt;
    next_byte_done   = byte_done;
    next_phase       = phase;
    next_index       = index;
    next_rw_read     = rw_read;
    next_nack        = nack;
    next_regs        = regs;
    shift_load       = 1'b0;
    shift_load_value = read_value(index);
    shift_en         = 1'b0;
    shift_bit        = ev.sda;
    case (state)
      CCR_ST_IDLE:
      begin
        next_state = CCR_ST_IDLE;
      end
      CCR_ST_RECV:
      begin
        if (ev.scl_rise)
        begin
          shift_en     = 1'b1;
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == CCR_LAST_BIT)
          begin
            next_byte_done = 1'b1;
          end
        end
        else if (ev.scl_fall && byte_done)
        begin
          next_byte_done = 1'b0;
          next_bit_cnt   = 3'h0;
          next_state     = CCR_ST_ACK;
          if (phase != CCR_PH_DATA)
          begin
            next_phase = phase + 2'h1; // R14
          end
          if (phase == CCR_PH_ADDR)
          begin
            next_rw_read = shift_data[0]; // R13
            if (shift_data[7:1] != CCR_SLAVE_ADDR)
            begin
              next_state = CCR_ST_IDLE; // R13
            end
          end
          else if (phase == CCR_PH_DATA)
          begin
            // Bits outside the mask stay one, so reserved bits read back one
            if (index < CCR_IDX_CHIP_ID) // R9
            begin
              next_regs[index] = (shift_data & CCR_WMASK[index]) | ~CCR_WMASK[index]; // R12
            end
            if (index != CCR_IDX_LAST)
            begin
              next_index = index + 3'h1;
            end
          end
        end
      end
      CCR_ST_ACK:
      begin
        if (ev.scl_fall)
        begin
          next_bit_cnt = 3'h0;
          if (rw_read)
          begin
            shift_load = 1'b1; // R16
            next_state = CCR_ST_SEND;
            if (index != CCR_IDX_LAST)
            begin
              next_index = index + 3'h1;
            end
          end
          else
          begin
            next_state = CCR_ST_RECV;
          end
        end
      end
      CCR_ST_SEND:
      begin
        if (ev.scl_fall)
        begin
          if (bit_cnt == CCR_LAST_BIT)
          begin
            next_bit_cnt = 3'h0;
            next_state   = CCR_ST_RACK;
          end
          else
          begin
            shift_en     = 1'b1;
            shift_bit    = 1'b1;
            next_bit_cnt = bit_cnt + 3'h1;
          end
        end
      end
      CCR_ST_RACK:
      begin
        if (ev.scl_rise)
        begin
          next_nack = ev.sda;
        end
        else if (ev.scl_fall)
        begin
          if (nack)
          begin
            next_state = CCR_ST_IDLE;
          end
          else
          begin
            shift_load = 1'b1; // R16
            next_state = CCR_ST_SEND;
            if (index != CCR_IDX_LAST)
            begin
              next_index = index + 3'h1;
            end
          end
        end
      end
      default:
      begin
        next_state = CCR_ST_IDLE;
      end
    endcase
    // A repeated start restarts at the address byte and index 0
    if (ev.start)
    begin
      next_state     = CCR_ST_RECV;
      next_bit_cnt   = 3'h0;
      next_byte_done = 1'b0;
      next_phase     = CCR_PH_ADDR;
      next_index     = CCR_IDX_FREQ_SEL; // R16
      next_nack      = 1'b0;
      shift_load     = 1'b0;
      shift_en       = 1'b0;
    end
    else if (ev.stop)
    begin
      next_state = CCR_ST_IDLE; // R16
    end
  end

  // Pin drive lags the state by one cycle, well inside the SCL low time
  always_comb
  begin
    next_sda_oe = (state == CCR_ST_ACK) || ((state == CCR_ST_SEND) && !shift_data[7]); // R13
  end

  // Enable outputs mirror the stored bytes
  always_comb
  begin
    next_enables.proc_clk_out        = regs[CCR_IDX_CPU][3:1]; // R1 R10
    next_enables.pci_bus_clk_out     = regs[CCR_IDX_PCI][6:0]; // R3 R10
    next_enables.mem_clk_out         = {regs[CCR_IDX_MEM_HIGH][7:4], regs[CCR_IDX_MEM_HIGH][2],
                                        regs[CCR_IDX_MEM_HIGH][0], regs[CCR_IDX_MEM_LOW]}; // R7 R8
    next_enables.ref_clk_out_first   = regs[CCR_IDX_FIXED][CCR_BIT_REF_FIRST_EN]; // R6
    next_enables.ref_clk_out_second  = regs[CCR_IDX_FIXED][CCR_BIT_REF_SECOND_EN]; // R6
    next_enables.fixed_48_out        = regs[CCR_IDX_FIXED][CCR_BIT_FIXED48_EN]; // R5
    next_enables.dual_rate_fixed_out = regs[CCR_IDX_FIXED][CCR_BIT_DUAL_EN]; // R5
    next_enables.dual_rate_sel_24    = regs[CCR_IDX_FIXED][CCR_BIT_DUAL_SEL]; // R4
    // Down-spread overrides the spread amount bit of index 0
    next_enables.spread_down         = ~regs[CCR_IDX_CPU][CCR_BIT_SPREAD_TYPE]; // R2
    next_enables.spread_center_wide  = regs[CCR_IDX_CPU][CCR_BIT_SPREAD_TYPE]
                                       & regs[CCR_IDX_FREQ_SEL][CCR_BIT_SPREAD_AMT]; // R2
  end

  // Only the power-up reset loads defaults; bus events never do
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      state       <= CCR_ST_IDLE;
      bit_cnt     <= 3'h0;
      byte_done   <= 1'b0;
      phase       <= CCR_PH_ADDR;
      index       <= CCR_IDX_FREQ_SEL;
      rw_read     <= 1'b0;
      nack        <= 1'b0;
      sda_oe      <= 1'b0;
      regs        <= {{(CCR_NUM_STORED - 1){CCR_RST_ENABLES}}, CCR_RST_FREQ_SEL}; // R10 R15
      strap_n     <= 4'h0;
      strap_taken <= 1'b0;
      // Spread flags match the reset bytes so both never show at once
      enables     <= '{spread_down: 1'b0, spread_center_wide: 1'b0, default: '1}; // R2 R10
    end
    else
    begin
      state       <= next_state;
      bit_cnt     <= next_bit_cnt;
      byte_done   <= next_byte_done;
      phase       <= next_phase;
      index       <= next_index;
      rw_read     <= next_rw_read;
      nack        <= next_nack;
      sda_oe      <= next_sda_oe;
      regs        <= next_regs;
      strap_n     <= next_strap_n;
      strap_taken <= next_strap_taken;
      enables     <= next_enables;
    end
  end

  // Open drain: the line is only ever pulled low
  assign o_serial_data_line    = 1'b0;
  assign o_serial_data_line_oe = sda_oe;
  assign o_enables             = enables;

endmodule // ccr_clock_regs

// *** verification/ccr_clock_regs_properties.sv ***
module ccr_clock_regs_properties
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  // Watched pins
  input  wire logic [3:0]   i_freq_strap_n,
  input  wire logic         i_serial_clock_line,
  input  wire logic         i_serial_data_line,
  input  wire logic         o_serial_data_line,
  input  wire logic         o_serial_data_line_oe,
  input  wire ccr_enables_t o_enables
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  a_data_value_low: assert property (o_serial_data_line == 1'b0)
    else $error("data pin value not low");
  a_ack_rise_low: assert property ($rose(o_serial_data_line_oe) |-> !i_serial_clock_line)
    else $error("data pulled while serial clock high");
  // A pull may follow a clock fall by three cycles, never later
  a_oe_stable_high: assert property (i_serial_clock_line [*5] |-> $stable(o_serial_data_line_oe))
    else $error("data pull changed during clock high");
  a_stop_stays_idle: assert property ($rose(i_serial_data_line) && i_serial_clock_line
    && $past(i_serial_clock_line) |-> !o_serial_data_line_oe [*8])
    else $error("data pulled after stop");
  a_spread_override: assert property (o_enables.spread_down |-> !o_enables.spread_center_wide)
    else $error("down spread and center spread both set");
  a_enables_after_fall: assert property ($changed(o_enables) && $past(i_resetn) && $past(i_resetn, 2)
    && $past(i_resetn, 3) |-> !(i_serial_clock_line && $past(i_serial_clock_line)
    && $past(i_serial_clock_line, 2) && $past(i_serial_clock_line, 3)))
    else $error("enables changed away from a clock fall");
  a_enables_power_up: assert property ($rose(i_resetn) |-> ((&o_enables.proc_clk_out)
    && (&o_enables.pci_bus_clk_out) && (&o_enables.mem_clk_out)) [*8])
    else $error("enables not running after reset");
  a_quiet_power_up: assert property ($rose(i_resetn) |-> !o_serial_data_line_oe [*8])
    else $error("data pulled right after reset");

  c_ack_seen: cover property ($rose(o_serial_data_line_oe));
  c_center: cover property (o_enables.spread_center_wide);
  c_pattern: cover property (o_enables.proc_clk_out == 3'h5);
endmodule // ccr_clock_regs_properties

// *** verification/ccr_master_model.sv ***
module ccr_master_model
(
  // Clock and resolved data wire
  input  wire logic i_clock,
  input  wire logic i_sda,
  // Driven lines, data one means released
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // Slow quarter bit leaves room for the device's three-cycle lag
  localparam int QTR = 4;

  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic wait_q();
    repeat (QTR) @(posedge i_clock);
  endtask

  task automatic send_start();
    wait_q();
    o_sda <= 1'b1;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    o_sda <= 1'b0;
    wait_q();
    o_scl <= 1'b0;
  endtask

  task automatic send_stop();
    wait_q();
    o_sda <= 1'b0;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    o_sda <= 1'b1;
    wait_q();
  endtask

  // Data moves only while the clock is low
  task automatic clock_bit(input logic v, output logic s);
    wait_q();
    o_sda <= v;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    s = i_sda;
    wait_q();
    o_scl <= 1'b0;
  endtask

  task automatic xfer_byte(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
    for (int i = 7; i >= 0; i--)
      clock_bit(tx[i], rx[i]);
    clock_bit(ack_tx, ack_rx);
  endtask
endmodule // ccr_master_model

// *** verification/tb.sv ***
module tb
  import ccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] ID = 8'h3C; // Arbitrary identification value
  localparam logic [7:0] WR = {CCR_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] RD = {CCR_SLAVE_ADDR, 1'b1};

  logic         i_clock;
  logic         i_resetn;
  logic [3:0]   i_freq_strap_n;
  logic         scl;
  logic         sda_drv;
  logic         sda_out;
  logic         sda_oe;
  logic         sda;
  ccr_enables_t enables;
  int           failures;
  int           comparisons;

  // Pull-up: low whenever either side pulls
  assign sda = sda_drv & ~(sda_oe & ~sda_out);

  ccr_clock_regs #(.CHIP_ID(ID)) i_dut (
    .i_clock               (i_clock),
    .i_resetn              (i_resetn),
    .i_freq_strap_n        (i_freq_strap_n),
    .i_serial_clock_line   (scl),
    .i_serial_data_line    (sda),
    .o_serial_data_line    (sda_out),
    .o_serial_data_line_oe (sda_oe),
    .o_enables             (enables)
  );

  ccr_master_model i_master (.i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda(sda_drv));

  always #2.5 i_clock = ~i_clock;

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_en(input ccr_enables_t got, input ccr_enables_t exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t enables %h expected %h", $time, got, exp);
    end
  endtask

  task automatic write_seq(input logic [7:0] bytes [$], input logic exp_nack);
    logic [7:0] rx;
    logic       ack;
    i_master.send_start();
    foreach (bytes[i])
    begin
      i_master.xfer_byte(bytes[i], 1'b1, rx, ack);
      check8({7'h0, ack}, {7'h0, exp_nack});
    end
    i_master.send_stop();
  endtask

  task automatic read_seq(input logic [7:0] exp [$]);
    logic [7:0] rx;
    logic       ack;
    i_master.send_start();
    i_master.xfer_byte(RD, 1'b1, rx, ack);
    check8({7'h0, ack}, 8'h00);
    foreach (exp[i])
    begin
      i_master.xfer_byte(8'hFF, (i == exp.size() - 1), rx, ack);
      check8(rx, exp[i]);
    end
    i_master.send_stop();
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clock);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    i_clock = 1'b0;
    i_resetn = 1'b0;
    i_freq_strap_n = 4'hA;
    failures = 0;
    comparisons = 0;
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clock);
    check_en(enables, 31'h7FFFFFFC);
    read_seq('{8'h00, 8'h7F, 8'hFF, 8'hBF, 8'hFF, 8'hFF, ID, 8'hFF});
    write_seq('{WR, 8'h5A, 8'hC3, 8'h80, 8'h0A, 8'h55, 8'h91, 8'hA4, 8'h3C, 8'h00}, 1'b0);
    check_en(enables, {3'h5, 7'h55, 14'h2A3C, 7'b1001110});
    read_seq('{8'h80, 8'h5B, 8'hD5, 8'h9D, 8'hAE, 8'h3C, ID});
    write_seq('{8'hD4, 8'h00, 8'h00, 8'hFF}, 1'b1);
    read_seq('{8'h80, 8'h5B});
    write_seq('{WR, 8'h00, 8'h00, 8'h80, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF}, 1'b0);
    check_en(enables, 31'h7FFFFFFD);
    read_seq('{8'h80, 8'h7F, 8'hFF, 8'hBF, 8'hFF, 8'hFF, ID, 8'hFF, 8'hFF});
    i_resetn <= 1'b0;
    i_freq_strap_n <= 4'h5;
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clock);
    // Straps move after capture and must not show
    i_freq_strap_n <= 4'hA;
    read_seq('{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hF5});
    tally_and_finish();
  end
endmodule // tb

bind ccr_clock_regs ccr_clock_regs_properties i_props (
  .i_clock               (i_clock),
  .i_resetn              (i_resetn),
  .i_freq_strap_n        (i_freq_strap_n),
  .i_serial_clock_line   (i_serial_clock_line),
  .i_serial_data_line    (i_serial_data_line),
  .o_serial_data_line    (o_serial_data_line),
  .o_serial_data_line_oe (o_serial_data_line_oe),
  .o_enables             (o_enables)
);
